//--- sdt_map.svh
// Register indices, field positions and reset values of the display timing block
`ifndef SDT_MAP_SVH
`define SDT_MAP_SVH

`define SDT_IDX_CTRL 4'h0
`define SDT_IDX_STATUS 4'h1
`define SDT_IDX_CLKDIV 4'h2
`define SDT_IDX_RATIO 4'h3
`define SDT_IDX_PCLK 4'h4
`define SDT_IDX_LINE 4'h5
`define SDT_IDX_HACT 4'h6
`define SDT_IDX_HSYNC 4'h7
`define SDT_IDX_VSYNC 4'h8
`define SDT_IDX_OFFS 4'h9
`define SDT_IDX_STROBE 4'hA
`define SDT_IDX_VFRM1 4'hB
`define SDT_IDX_VFRM2 4'hC
`define SDT_CFG_FIRST 2
`define SDT_CFG_LAST 12

`define SDT_ADDR_IDX 5:2
`define SDT_ADDR_TOP 11:6
`define SDT_LO 15:0
`define SDT_HI 31:16

`define SDT_CTRL_EN 0
`define SDT_CTRL_COMMIT 1
`define SDT_STAT_BUSY 0
`define SDT_STAT_RUN 1
`define SDT_STAT_VSYNC 2

`define SDT_RST_CLKDIV 32'h0000_0020
`define SDT_RST_RATIO 32'h0000_0010
`define SDT_RST_PCLK 32'h0002_0000
`define SDT_RST_LINE 32'h0000_0320
`define SDT_RST_HACT 32'h0280_0058
`define SDT_RST_HSYNC 32'h0060_0000
`define SDT_RST_VSYNC 32'h0640_0000
`define SDT_RST_VFRM1 32'h0002_000A
`define SDT_RST_VFRM2 32'h01E0_0021
`define SDT_RST_ZERO 32'h0000_0000

`endif

//--- sdt_pkg.sv
// Types shared by the display timing block
`default_nettype none
package sdt_pkg;
   typedef logic [31:0] sdt_word_t;
   typedef logic [1:0] sdt_half_t;
   typedef enum logic [3:0] {
      SDT_V_SYNC = 4'h1,
      SDT_V_BACK = 4'h2,
      SDT_V_ACTIVE = 4'h4,
      SDT_V_FRONT = 4'h8
   } sdt_vstate_e;
endpackage : sdt_pkg
`default_nettype wire

//--- sdt_display_timing.sv
// Synchronous TFT panel timing generator with APB configuration
// Each control output is a pair: bit 0 is the first half of a base clock
// cycle, bit 1 the second half; a DDR output cell merges them.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdt_map.svh"
module sdt_display_timing #(
   parameter int DATA_WIDTH = 24,
   parameter int STROBE_DEPTH = 8
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic baseDisplayClock,
   input wire logic [DATA_WIDTH-1:0] pixelIn,
   output logic pixelTake,
   output logic [1:0] pixelClockOut,
   output logic [1:0] lineSyncOut,
   output logic [1:0] frameSyncOut,
   output logic [1:0] activeDataStrobe,
   output logic [DATA_WIDTH-1:0] pixelDataOut
);

   // Level of one half cycle: half position within [start, stop)
   function automatic logic halfLevel(input logic [15:0] pos, input logic half,
                                      input logic [16:0] start, input logic [16:0] stop);
      logic [16:0] h;
      h = {pos, half};
      halfLevel = (h >= start) && (h < stop);
   endfunction : halfLevel

   function automatic logic [16:0] edgeAt(input logic [15:0] offset, input logic [15:0] edgeVal);
      edgeAt = {1'b0, offset} + {1'b0, edgeVal};
   endfunction : edgeAt

   function automatic sdt_pkg::sdt_word_t resetWord(input int idx);
      unique case (idx)
         `SDT_IDX_CLKDIV: resetWord = `SDT_RST_CLKDIV;
         `SDT_IDX_RATIO: resetWord = `SDT_RST_RATIO;
         `SDT_IDX_PCLK: resetWord = `SDT_RST_PCLK;
         `SDT_IDX_LINE: resetWord = `SDT_RST_LINE;
         `SDT_IDX_HACT: resetWord = `SDT_RST_HACT;
         `SDT_IDX_HSYNC: resetWord = `SDT_RST_HSYNC;
         `SDT_IDX_VSYNC: resetWord = `SDT_RST_VSYNC;
         `SDT_IDX_VFRM1: resetWord = `SDT_RST_VFRM1;
         `SDT_IDX_VFRM2: resetWord = `SDT_RST_VFRM2;
         default: resetWord = `SDT_RST_ZERO;
      endcase
   endfunction : resetWord

   function automatic logic [15:0] satInc(input logic [15:0] v);
      satInc = (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction : satInc

   // APB domain
   sdt_pkg::sdt_word_t cfgReg [`SDT_CFG_FIRST:`SDT_CFG_LAST];
   logic enableReg;
   logic reqTogReg;
   logic ackTogReg, ackMetaReg, ackSyncReg;
   logic runReg, runMetaReg, runSyncReg;
   logic inSyncReg, vsMetaReg, vsSyncReg;
   logic [31:0] prdataReg;
   logic [3:0] regIdx;
   logic mapped, busy, wrTake;

   assign regIdx = paddr[`SDT_ADDR_IDX];
   assign mapped = (paddr[`SDT_ADDR_TOP] == 6'h00) && (paddr[1:0] == 2'h0)
                   && (regIdx <= 4'(`SDT_CFG_LAST));
   assign busy = reqTogReg ^ ackSyncReg;
   // Writes while a commit is in flight are dropped
   assign wrTake = psel && penable && pwrite && mapped && !busy;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdataReg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = `SDT_CFG_FIRST; i <= `SDT_CFG_LAST; i++) begin
            cfgReg[i] <= resetWord(i);
         end
      end else begin
         for (int i = `SDT_CFG_FIRST; i <= `SDT_CFG_LAST; i++) begin
            if (wrTake && regIdx == 4'(i)) begin
               cfgReg[i] <= pwdata;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         enableReg <= 1'b0;
         reqTogReg <= 1'b0;
      end else if (wrTake && regIdx == `SDT_IDX_CTRL) begin
         enableReg <= pwdata[`SDT_CTRL_EN];
         reqTogReg <= reqTogReg ^ pwdata[`SDT_CTRL_COMMIT];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ackMetaReg <= 1'b0;
         ackSyncReg <= 1'b0;
         runMetaReg <= 1'b0;
         runSyncReg <= 1'b0;
         vsMetaReg <= 1'b0;
         vsSyncReg <= 1'b0;
      end else begin
         ackMetaReg <= ackTogReg;
         ackSyncReg <= ackMetaReg;
         runMetaReg <= runReg;
         runSyncReg <= runMetaReg;
         vsMetaReg <= inSyncReg;
         vsSyncReg <= vsMetaReg;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prdataReg <= `SDT_RST_ZERO;
      end else if (psel && !penable) begin
         if (!mapped) begin
            prdataReg <= `SDT_RST_ZERO;
         end else if (regIdx == `SDT_IDX_CTRL) begin
            prdataReg <= {31'h0000_0000, enableReg};
         end else if (regIdx == `SDT_IDX_STATUS) begin
            prdataReg <= {29'h0000_0000, vsSyncReg, runSyncReg, busy};
         end else begin
            prdataReg <= cfgReg[regIdx];
         end
      end
   end

   // Base display clock domain
   logic baseRstMetaReg, baseRstnReg;
   logic reqMetaReg, reqSyncReg;
   logic enMetaReg, enSyncReg;
   sdt_pkg::sdt_word_t cfgBase [`SDT_CFG_FIRST:`SDT_CFG_LAST];

   always_ff @(posedge baseDisplayClock or negedge rstn) begin
      if (!rstn) begin
         baseRstMetaReg <= 1'b0;
         baseRstnReg <= 1'b0;
      end else begin
         baseRstMetaReg <= 1'b1;
         baseRstnReg <= baseRstMetaReg;
      end
   end

   // Config words are frozen while the toggle is unacknowledged
   always_ff @(posedge baseDisplayClock or negedge baseRstnReg) begin
      if (!baseRstnReg) begin
         reqMetaReg <= 1'b0;
         reqSyncReg <= 1'b0;
         ackTogReg <= 1'b0;
         enMetaReg <= 1'b0;
         enSyncReg <= 1'b0;
         runReg <= 1'b0;
         for (int i = `SDT_CFG_FIRST; i <= `SDT_CFG_LAST; i++) begin
            cfgBase[i] <= resetWord(i);
         end
      end else begin
         reqMetaReg <= reqTogReg;
         reqSyncReg <= reqMetaReg;
         enMetaReg <= enableReg;
         enSyncReg <= enMetaReg;
         runReg <= enSyncReg;
         if (reqSyncReg != ackTogReg) begin
            ackTogReg <= reqSyncReg;
            for (int i = `SDT_CFG_FIRST; i <= `SDT_CFG_LAST; i++) begin
               cfgBase[i] <= cfgReg[i];
            end
         end
      end
   end

   logic [15:0] clkDivisor, clockRatio, pclkOffset, pclkHigh, lineLengthCount;
   logic [15:0] actStart, actCount, hUp, hDown, vUp, vDown, hOffset, vOffset;
   logic [15:0] dataStrobeOffset, vFront, vSync, vBack, vActive;
   assign clkDivisor = cfgBase[`SDT_IDX_CLKDIV][`SDT_LO];
   assign clockRatio = cfgBase[`SDT_IDX_RATIO][`SDT_LO];
   assign pclkOffset = cfgBase[`SDT_IDX_PCLK][`SDT_LO];
   assign pclkHigh = cfgBase[`SDT_IDX_PCLK][`SDT_HI];
   assign lineLengthCount = cfgBase[`SDT_IDX_LINE][`SDT_LO];
   assign actStart = cfgBase[`SDT_IDX_HACT][`SDT_LO];
   assign actCount = cfgBase[`SDT_IDX_HACT][`SDT_HI];
   assign hUp = cfgBase[`SDT_IDX_HSYNC][`SDT_LO];
   assign hDown = cfgBase[`SDT_IDX_HSYNC][`SDT_HI];
   assign vUp = cfgBase[`SDT_IDX_VSYNC][`SDT_LO];
   assign vDown = cfgBase[`SDT_IDX_VSYNC][`SDT_HI];
   assign hOffset = cfgBase[`SDT_IDX_OFFS][`SDT_LO];
   assign vOffset = cfgBase[`SDT_IDX_OFFS][`SDT_HI];
   assign dataStrobeOffset = cfgBase[`SDT_IDX_STROBE][`SDT_LO];
   assign vFront = cfgBase[`SDT_IDX_VFRM1][`SDT_LO];
   assign vSync = cfgBase[`SDT_IDX_VFRM1][`SDT_HI];
   assign vBack = cfgBase[`SDT_IDX_VFRM2][`SDT_LO];
   assign vActive = cfgBase[`SDT_IDX_VFRM2][`SDT_HI];

   // Pixel clock phase accumulator
   logic [16:0] accReg, accSum;
   logic pixTick;
   assign accSum = accReg + {1'b0, clockRatio};
   // period is floor or floor plus one base clock
   assign pixTick = runReg && (accSum >= {1'b0, clkDivisor});

   // ratio added per base clock, divisor per pixel
   always_ff @(posedge baseDisplayClock or negedge baseRstnReg) begin
      if (!baseRstnReg) begin
         accReg <= 17'h0_0000;
      end else if (!runReg) begin
         accReg <= 17'h0_0000;
      end else if (pixTick) begin
         accReg <= accSum - {1'b0, clkDivisor};
      end else begin
         accReg <= accSum;
      end
   end

   // Line and frame position
   logic [15:0] pixCntReg, pixCntNext, lineInStateReg, lineInStateNext;
   logic [15:0] sinceLineReg, sinceLineNext, sincePixReg, sincePixNext;
   logic lineWrap, activeNext;
   sdt_pkg::sdt_vstate_e vStateReg, vStateNext;
   logic [15:0] stateLen;

   always_comb begin
      stateLen = 16'h0000;
      unique case (vStateReg)
         sdt_pkg::SDT_V_SYNC: stateLen = vSync;
         sdt_pkg::SDT_V_BACK: stateLen = vBack;
         sdt_pkg::SDT_V_ACTIVE: stateLen = vActive;
         sdt_pkg::SDT_V_FRONT: stateLen = vFront;
      endcase
   end

   // line wraps after line length count pixels
   assign lineWrap = pixTick && (pixCntReg + 16'h0001 >= lineLengthCount);

   // frame counter steps sync, back, active, front
   always_comb begin
      vStateNext = vStateReg;
      lineInStateNext = lineInStateReg;
      if (!runReg) begin
         vStateNext = sdt_pkg::SDT_V_SYNC;
         lineInStateNext = 16'h0000;
      end else if (lineWrap) begin
         if (lineInStateReg + 16'h0001 >= stateLen) begin
            lineInStateNext = 16'h0000;
            unique case (vStateReg)
               sdt_pkg::SDT_V_SYNC: vStateNext = sdt_pkg::SDT_V_BACK;
               sdt_pkg::SDT_V_BACK: vStateNext = sdt_pkg::SDT_V_ACTIVE;
               sdt_pkg::SDT_V_ACTIVE: vStateNext = sdt_pkg::SDT_V_FRONT;
               sdt_pkg::SDT_V_FRONT: vStateNext = sdt_pkg::SDT_V_SYNC;
            endcase
         end else begin
            lineInStateNext = lineInStateReg + 16'h0001;
         end
      end
   end

   // local start point is the base cycle after line wrap
   assign pixCntNext = !runReg ? 16'h0000 : lineWrap ? 16'h0000 :
                       pixTick ? pixCntReg + 16'h0001 : pixCntReg;
   assign sinceLineNext = (!runReg || lineWrap) ? 16'h0000 : satInc(sinceLineReg);
   assign sincePixNext = (!runReg || pixTick) ? 16'h0000 : satInc(sincePixReg);
   assign activeNext = (vStateNext == sdt_pkg::SDT_V_ACTIVE) && (pixCntNext >= actStart)
                       && ({1'b0, pixCntNext} < {1'b0, actStart} + {1'b0, actCount});
   assign pixelTake = pixTick && activeNext;

   always_ff @(posedge baseDisplayClock or negedge baseRstnReg) begin
      if (!baseRstnReg) begin
         pixCntReg <= 16'h0000;
         sinceLineReg <= 16'h0000;
         sincePixReg <= 16'h0000;
         vStateReg <= sdt_pkg::SDT_V_SYNC;
         lineInStateReg <= 16'h0000;
      end else begin
         pixCntReg <= pixCntNext;
         sinceLineReg <= sinceLineNext;
         sincePixReg <= sincePixNext;
         vStateReg <= vStateNext;
         lineInStateReg <= lineInStateNext;
      end
   end

   // Pixel data
   logic dataActiveReg, dataActiveNext;
   logic [DATA_WIDTH-1:0] pixelDataReg;
   assign dataActiveNext = !runReg ? 1'b0 : pixTick ? activeNext : dataActiveReg;
   assign pixelDataOut = pixelDataReg;

   // data loads on whole base clock edges only
   // data fixed to pixel tick after start point
   always_ff @(posedge baseDisplayClock or negedge baseRstnReg) begin
      if (!baseRstnReg) begin
         pixelDataReg <= '0;
         dataActiveReg <= 1'b0;
      end else begin
         dataActiveReg <= dataActiveNext;
         if (!runReg || (pixTick && !activeNext)) begin
            pixelDataReg <= '0;
         end else if (pixelTake) begin
            pixelDataReg <= pixelIn;
         end
      end
   end

   // Strobe history, index 0 is the data valid of the coming cycle
   logic [STROBE_DEPTH-1:0] dataHistReg;
   logic [STROBE_DEPTH:0] dataSeq;
   logic [15:0] strobeOff;
   logic [15:0] idxFirst, idxSecond;
   assign dataSeq = {dataHistReg, dataActiveNext};
   assign strobeOff = (dataStrobeOffset > 16'(2 * STROBE_DEPTH)) ? 16'(2 * STROBE_DEPTH) : dataStrobeOffset;
   assign idxFirst = (strobeOff + 16'h0001) >> 1;
   assign idxSecond = strobeOff >> 1;

   always_ff @(posedge baseDisplayClock or negedge baseRstnReg) begin
      if (!baseRstnReg) begin
         dataHistReg <= '0;
      end else begin
         dataHistReg <= dataSeq[STROBE_DEPTH-1:0];
      end
   end

   // Control outputs
   logic [1:0] pclkReg, hsyncReg, vsyncReg, strobeReg;
   logic inSyncNext;
   assign inSyncNext = runReg && (vStateNext == sdt_pkg::SDT_V_SYNC);
   assign pixelClockOut = pclkReg;
   assign lineSyncOut = hsyncReg;
   assign frameSyncOut = vsyncReg;
   assign activeDataStrobe = strobeReg;

   // four controls beside the data bus
   // pixel clock from the base cycle count since the pixel tick, line and frame sync from the shared line counter, strobe from the data history
   // controls resolved to half base clock
   always_ff @(posedge baseDisplayClock or negedge baseRstnReg) begin
      if (!baseRstnReg) begin
         pclkReg <= 2'h0;
         hsyncReg <= 2'h0;
         vsyncReg <= 2'h0;
         strobeReg <= 2'h0;
         inSyncReg <= 1'b0;
      end else begin
         inSyncReg <= inSyncNext;
         for (int k = 0; k < 2; k++) begin
            // pixel clock offset from pixel start
            pclkReg[k] <= runReg && halfLevel(sincePixNext, k[0], {1'b0, pclkOffset},
                                              edgeAt(pclkOffset, pclkHigh));
            // offset plus up and down edges
            // line sync relative to start point
            hsyncReg[k] <= runReg && halfLevel(sinceLineNext, k[0], edgeAt(hOffset, hUp),
                                               edgeAt(hOffset, hDown));
            // frame sync on sync lines only
            vsyncReg[k] <= inSyncNext && halfLevel(sinceLineNext, k[0], edgeAt(vOffset, vUp),
                                                   edgeAt(vOffset, vDown));
         end
         // strobe delayed from data in half steps
         strobeReg[0] <= (idxFirst <= 16'(STROBE_DEPTH)) && dataSeq[idxFirst[$clog2(STROBE_DEPTH+1)-1:0]];
         strobeReg[1] <= dataSeq[idxSecond[$clog2(STROBE_DEPTH+1)-1:0]];
      end
   end

endmodule : sdt_display_timing
`default_nettype wire

//--- sdt_display_timing_properties.sv
// Port assertions and covers for the panel timing block
`timescale 1ns/1ps
`default_nettype none
module sdt_display_timing_properties #(
   parameter int DATA_WIDTH = 24,
   parameter int STROBE_DEPTH = 8
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic baseDisplayClock,
   input wire logic [DATA_WIDTH-1:0] pixelIn,
   input wire logic pixelTake,
   input wire logic [1:0] pixelClockOut,
   input wire logic [1:0] lineSyncOut,
   input wire logic [1:0] frameSyncOut,
   input wire logic [1:0] activeDataStrobe,
   input wire logic [DATA_WIDTH-1:0] pixelDataOut
);
   logic setupPhase, accessPhase, unmapped;
   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign unmapped = (paddr[11:6] != 6'h00) || (paddr[1:0] != 2'h0) || (paddr[5:2] > 4'hC);
   a_ready_always: assert property (@(posedge clock) disable iff (!rstn) accessPhase |-> pready)
      else $error("pready low in access phase");
   a_unmapped_error: assert property (@(posedge clock) disable iff (!rstn) accessPhase && unmapped |-> pslverr)
      else $error("no error on unmapped access");
   a_mapped_clean: assert property (@(posedge clock) disable iff (!rstn) accessPhase && !unmapped |-> !pslverr)
      else $error("error on mapped access");
   a_error_in_access: assert property (@(posedge clock) disable iff (!rstn) pslverr |-> accessPhase)
      else $error("error outside access phase");
   a_unmapped_zero: assert property (@(posedge clock) disable iff (!rstn)
      accessPhase && !pwrite && unmapped |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
   a_read_hold: assert property (@(posedge clock) disable iff (!rstn) $changed(prdata) |-> $past(setupPhase))
      else $error("read data moved outside setup");
   a_pixel_capture: assert property (@(posedge baseDisplayClock) disable iff (!rstn)
      pixelTake |=> pixelDataOut == $past(pixelIn)) else $error("pixel not placed after take");
   a_data_on_take: assert property (@(posedge baseDisplayClock) disable iff (!rstn)
      $changed(pixelDataOut) && (pixelDataOut != '0) |-> $past(pixelTake)) else $error("data moved without take");
   a_release_quiet: assert property (@(posedge baseDisplayClock) disable iff (!rstn)
      $rose(rstn) |-> {pixelTake, pixelClockOut, lineSyncOut, frameSyncOut, activeDataStrobe, pixelDataOut} == '0)
      else $error("outputs active right after reset");
   c_take: cover property (@(posedge baseDisplayClock) disable iff (!rstn) pixelTake);
   c_line: cover property (@(posedge baseDisplayClock) disable iff (!rstn) $rose(lineSyncOut[0]));
   c_frame: cover property (@(posedge baseDisplayClock) disable iff (!rstn) $rose(frameSyncOut[0]));
   c_error: cover property (@(posedge clock) disable iff (!rstn) pslverr);
endmodule : sdt_display_timing_properties
bind sdt_display_timing sdt_display_timing_properties #(.DATA_WIDTH(DATA_WIDTH), .STROBE_DEPTH(STROBE_DEPTH)) chk (
   .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .baseDisplayClock(baseDisplayClock),
   .pixelIn(pixelIn), .pixelTake(pixelTake), .pixelClockOut(pixelClockOut), .lineSyncOut(lineSyncOut),
   .frameSyncOut(frameSyncOut), .activeDataStrobe(activeDataStrobe), .pixelDataOut(pixelDataOut));
`default_nettype wire

//--- sdt_panel_model.sv
// Panel model measuring sync, strobe and pixel clock timing in half cycles
`timescale 1ns/1ps
`default_nettype none
module sdt_panel_model (
   input wire logic baseDisplayClock,
   input wire logic rstn,
   input wire logic [1:0] pixelClockOut,
   input wire logic [1:0] lineSyncOut,
   input wire logic [1:0] frameSyncOut,
   input wire logic [1:0] activeDataStrobe,
   output logic [15:0] frameCount,
   output logic [15:0] meas [0:5],
   output logic [2:0] riseOdd
);
   logic [15:0] acc [0:4];
   logic [15:0] add [0:4];
   logic [15:0] halfNow, lastLine;
   logic [2:0] lastHi, rise0, rise1;
   always_comb begin
      rise0 = {pixelClockOut[0], frameSyncOut[0], lineSyncOut[0]} & ~lastHi;
      rise1 = {pixelClockOut[1], frameSyncOut[1], lineSyncOut[1]} & ~{pixelClockOut[0], frameSyncOut[0], lineSyncOut[0]};
      add[0] = 16'(rise0[0] | rise1[0]);
      add[1] = 16'(lineSyncOut[0]) + 16'(lineSyncOut[1]);
      add[2] = 16'(frameSyncOut[0]) + 16'(frameSyncOut[1]);
      add[3] = 16'(activeDataStrobe[0]) + 16'(activeDataStrobe[1]);
      add[4] = 16'(pixelClockOut[0]) + 16'(pixelClockOut[1]);
   end
   // Totals latched at each frame start
   always_ff @(posedge baseDisplayClock or negedge rstn) begin
      if (!rstn) begin
         frameCount <= '0;
         halfNow <= '0;
         lastLine <= '0;
         lastHi <= '0;
         riseOdd <= '0;
         for (int i = 0; i < 6; i++) meas[i] <= '0;
         for (int i = 0; i < 5; i++) acc[i] <= '0;
      end else begin
         halfNow <= halfNow + 16'h0002;
         lastHi <= {pixelClockOut[1], frameSyncOut[1], lineSyncOut[1]};
         for (int i = 0; i < 3; i++) if (rise0[i] | rise1[i]) riseOdd[i] <= !rise0[i];
         if (add[0] != '0) begin
            meas[5] <= halfNow + 16'(!rise0[0]) - lastLine;
            lastLine <= halfNow + 16'(!rise0[0]);
         end
         if (rise0[1] | rise1[1]) frameCount <= frameCount + 16'h0001;
         for (int i = 0; i < 5; i++) begin
            if (rise0[1] | rise1[1]) begin
               meas[i] <= acc[i];
               acc[i] <= add[i];
            end else begin
               acc[i] <= acc[i] + add[i];
            end
         end
      end
   end
endmodule : sdt_panel_model
`default_nettype wire

//--- sync_tft_display_timing_test.sv
// Self-checking testbench for the panel timing block
`timescale 1ns/1ps
`default_nettype none
`include "sdt_map.svh"
module sync_tft_display_timing_test;
   localparam int VL = 5, HS = 4, AL = 2, PX = 8, LN = 20, DIV = 40, RAT = 16, PW = 2;
   logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, baseDisplayClock = 0, pend = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r, v;
   logic pready, pslverr, pixelTake;
   logic [23:0] pixelIn = '0, pixelDataOut;
   logic [1:0] pclk, lsync, fsync, strobe;
   logic [15:0] frameCount, f;
   logic [15:0] meas [0:5];
   logic [2:0] riseOdd;
   logic [33:0] e;
   logic [33:0] expQ [$];
   logic [23:0] pixQ [$];
   logic [31:0] rv [0:12] = '{32'h0000_0000, 32'h0000_0000, `SDT_RST_CLKDIV, `SDT_RST_RATIO, `SDT_RST_PCLK,
      `SDT_RST_LINE, `SDT_RST_HACT, `SDT_RST_HSYNC, `SDT_RST_VSYNC, `SDT_RST_ZERO, `SDT_RST_ZERO,
      `SDT_RST_VFRM1, `SDT_RST_VFRM2};
   logic [31:0] cfg [0:12] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0028, 32'h0000_0010, 32'h0002_0000,
      32'h0000_0014, 32'h0008_0004, 32'h0004_0000, 32'h0004_0000, 32'h0000_0000, 32'h0000_0002,
      32'h0001_0001, 32'h0002_0001};
   int miscompares = 0, total_checks = 0, cycles = 0, gap = 100, n;
   sdt_display_timing uut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .baseDisplayClock(baseDisplayClock), .pixelIn(pixelIn), .pixelTake(pixelTake), .pixelClockOut(pclk),
      .lineSyncOut(lsync), .frameSyncOut(fsync), .activeDataStrobe(strobe), .pixelDataOut(pixelDataOut));
   sdt_panel_model panel (.baseDisplayClock(baseDisplayClock), .rstn(rstn), .pixelClockOut(pclk),
      .lineSyncOut(lsync), .frameSyncOut(fsync), .activeDataStrobe(strobe), .frameCount(frameCount),
      .meas(meas), .riseOdd(riseOdd));
   initial forever #20 clock = ~clock;
   initial begin
      #7;
      forever #15 baseDisplayClock = ~baseDisplayClock;
   end
   function automatic logic [11:0] ad(input int i);
      return {6'h00, 4'(i), 2'b00};
   endfunction : ad
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   // ex: bit0 compare read data, bit1 error expected, bit2 next transfer follows at once
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [2:0] ex);
      expQ.push_back({ex[1:0], d});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      penable <= 1'b0;
      if (!ex[2]) begin
         psel <= 1'b0;
         @(posedge clock);
      end
   endtask : apb
   task automatic waitStatus(input int b, input logic want);
      n = 0;
      do begin
         apb(1'b0, ad(1), 32'h0, 3'b000);
         n++;
      end while (r[b] !== want && n < 100);
      check({31'h0, r[b]}, {31'h0, want}, "status bit");
   endtask : waitStatus
   task automatic run(input logic [2:0] odd);
      apb(1'b1, ad(0), 32'h0000_0001, 3'b000);
      waitStatus(1, 1'b1);
      f = frameCount + 16'h0003;
      wait (frameCount === f);
      @(posedge clock);
      check(32'(meas[0]), VL, "lines per frame");
      check(32'(meas[1]), VL * HS, "line sync halves");
      check(32'(meas[2]), HS, "frame sync halves");
      check(32'(meas[3]), 2 * AL * PX * DIV / RAT, "strobe halves");
      check(32'(meas[4]), VL * LN * PW, "pixel clock halves");
      check(32'(meas[5]), 2 * LN * DIV / RAT, "line period halves");
      check(32'(riseOdd), 32'(odd), "rise half parity");
   endtask : run
   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1) begin
         e = expQ.pop_front();
         check({31'h0, pslverr}, {31'h0, e[33]}, "error flag");
         if (e[32]) check(prdata, e[31:0], "read data");
      end
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         $display("ERROR %0t timeout", $time);
         final_report();
      end
   end
   always @(posedge baseDisplayClock) begin
      if (pend) check({8'h00, pixelDataOut}, {8'h00, pixQ.pop_front()}, "pixel data");
      pend = (pixelTake === 1'b1);
      gap++;
      if (pend) begin
         check(32'(gap == 2 || gap == 3 || gap >= 10), 32'h1, "pixel period");
         gap = 0;
         pixQ.push_back(pixelIn);
         pixelIn <= 24'($urandom);
      end
   end
   initial begin
      void'($urandom(32'h1fd5));
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 13; i++) apb(1'b0, ad(i), rv[i], 3'b001);
      apb(1'b0, 12'h034, 32'h0, 3'b011);
      apb(1'b1, 12'h040, 32'hffff_ffff, 3'b010);
      apb(1'b0, 12'h00a, 32'h0, 3'b011);
      $display("test reset and map done");
      for (int i = 2; i < 13; i++) begin
         v = $urandom;
         apb(1'b1, ad(i), v, 3'b000);
         apb(1'b0, ad(i), v, 3'b001);
      end
      $display("test readback done");
      for (int i = 2; i < 13; i++) apb(1'b1, ad(i), cfg[i], 3'b000);
      apb(1'b1, ad(0), 32'h0000_0002, 3'b100);
      apb(1'b1, ad(2), $urandom, 3'b000);
      waitStatus(0, 1'b0);
      apb(1'b0, ad(2), cfg[2], 3'b001);
      run(3'b000);
      $display("test frame timing done");
      apb(1'b1, ad(0), 32'h0000_0000, 3'b000);
      waitStatus(1, 1'b0);
      check({pclk, lsync, fsync, strobe, pixelDataOut}, 32'h0, "outputs while stopped");
      apb(1'b1, ad(4), 32'h0002_0001, 3'b000);
      apb(1'b1, ad(9), 32'h0000_0003, 3'b000);
      apb(1'b1, ad(0), 32'h0000_0002, 3'b000);
      waitStatus(0, 1'b0);
      run(3'b101);
      $display("test half offsets done");
      final_report();
   end
endmodule : sync_tft_display_timing_test
`default_nettype wire
